// *** hdl/tksr_pkg.sv ***
/*
  Shared constants and types for the tone key serial readout ends.
  Assumes both ends run on clk at 125 MHz with an active-low reset.
*/
package tksr_pkg;

  // Width of one key code and number of bits shifted per key.
  localparam int unsigned CodeWidth = 4;
  localparam int unsigned BitsPerKey = 4;

  // Depth and width of the host's receive FIFO.
  localparam int unsigned FifoDepth = 32;
  localparam int unsigned FifoWidth = CodeWidth;

  // Key codes.
  localparam logic [3:0] KeyZero  = 4'ha;
  localparam logic [3:0] KeyStar  = 4'hb;
  localparam logic [3:0] KeyHash  = 4'hc;
  localparam logic [3:0] KeyA     = 4'hd;
  localparam logic [3:0] KeyD     = 4'h0;

  // Reset values.
  localparam logic [3:0] CodeReset = 4'h0;
  localparam logic [2:0] CountReset = 3'h0;

  // Acknowledge clock: half period in clk cycles (80 ns period at 8 ns).
  localparam int unsigned AckPeriodNs = 80;
  localparam int unsigned ClkPeriodNs = 8;
  localparam int unsigned AckHalfCycles = AckPeriodNs / ClkPeriodNs / 2;

  // Settle time after early-steering rises before reading.
  localparam int unsigned GuardNs = 400;
  localparam int unsigned GuardCycles = (GuardNs + ClkPeriodNs - 1)
                                        / ClkPeriodNs;

  // Row and column index types.
  typedef logic [1:0] tksr_idx_t;

endpackage

// *** hdl/tksr_link_if.sv ***
/*
  Pins between the keypad receiver device and the host.
  Assumes the bench joins both modports and drives a common clock.
*/
`timescale 1ns/1ps
interface tksr_link_if;
  logic earlySteering;
  logic serialCode;
  logic ackPulse;
  logic sleepRequest;

  modport device (
    output earlySteering,
    output serialCode,
    input  ackPulse,
    input  sleepRequest
  );

  modport host (
    input  earlySteering,
    input  serialCode,
    output ackPulse,
    output sleepRequest
  );
endinterface

// *** hdl/tksr_device.sv ***
/*
  Device end of the tone key serial readout: code conversion, early
  steering and the parallel-to-serial shifter driven by acknowledge.
  The shifter latches the code on the first accepted acknowledge rise
  and shows one bit per rise, lowest bit first, for four rises. A sleep
  cycle while a key is held rearms the shifter so the code can be read
  again; steering and the serial line stay frozen while asleep.
  Assumes the host keeps acknowledge low whenever it raises sleep.
  Assumes the row and column detector outputs are steady levels from
  the analog front end; link pins pass two flip-flops before use.
*/
`timescale 1ns/1ps

module tksr_device (
  input  wire logic              clk,
  input  wire logic              nrst,
  tksr_link_if.device            link,
  input  wire logic              toneValid,
  input  wire tksr_pkg::tksr_idx_t rowIdx,
  input  wire tksr_pkg::tksr_idx_t colIdx,
  output logic                   sleeping
);

  // Shifter progress for one key: waiting for the first acknowledge,
  // shifting out the remaining bits, or finished until the key drops or a sleep cycle rearms it.
  typedef enum logic [1:0] {TKSR_IDLE, TKSR_SHIFT, TKSR_DONE} tksr_state_t;

  // Link input synchronisers and their edge history.
  logic [1:0]  ackSync_q;
  logic [1:0]  ackSync_d;
  logic [1:0]  sleepSync_q;
  logic [1:0]  sleepSync_d;
  logic        ackPrev_q;
  logic        ackPrev_d;
  logic        sleepPrev_q;
  logic        sleepPrev_d;
  logic        ackRise;
  logic        sleepRise;

  // Code converter output.
  logic [3:0]  keyCode;

  // Power-down state.
  logic        sleep_q;
  logic        sleep_d;

  // Early-steering output register.
  logic        steer_q;
  logic        steer_d;

  // Parallel-to-serial shifter.
  logic [3:0]  shift_q;
  logic [3:0]  shift_d;
  logic [2:0]  count_q;
  logic [2:0]  count_d;
  logic        serial_q;
  logic        serial_d;
  tksr_state_t state_q;
  tksr_state_t state_d;

  // Next values of the synchronisers: the first stage takes the pin, the
  // second takes the first, and the history keeps the settled level.
  always_comb begin
    ackSync_d   = {ackSync_q[0], link.ackPulse};
    sleepSync_d = {sleepSync_q[0], link.sleepRequest};
    ackPrev_d   = ackSync_q[1];
    sleepPrev_d = sleepSync_q[1];
  end

  // Synchroniser registers; they reset to the idle low level of both
  // pins so no false edge is seen when reset is released.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackSync_q   <= 2'h0;
      sleepSync_q <= 2'h0;
      ackPrev_q   <= 1'b0;
      sleepPrev_q <= 1'b0;
    end else begin
      ackSync_q   <= ackSync_d;
      sleepSync_q <= sleepSync_d;
      ackPrev_q   <= ackPrev_d;
      sleepPrev_q <= sleepPrev_d;
    end
  end

  // Rising edges are taken from the settled stage only.
  assign ackRise   = ackSync_q[1] & ~ackPrev_q;
  assign sleepRise = sleepSync_q[1] & ~sleepPrev_q;

  // Row-major table lookup from tone indices to the 4-bit code.
  always_comb begin
    keyCode = tksr_pkg::KeyD;
    if (colIdx == 2'h3) begin
      keyCode = (rowIdx == 2'h3) ? tksr_pkg::KeyD
                : 4'(tksr_pkg::KeyA + 4'(rowIdx));
    end else if (rowIdx == 2'h3) begin
      case (colIdx)
        2'h0:    keyCode = tksr_pkg::KeyStar;
        2'h1:    keyCode = tksr_pkg::KeyZero;
        default: keyCode = tksr_pkg::KeyHash;
      endcase
    end else begin
      keyCode = 4'(4'(rowIdx) * 4'h3 + 4'(colIdx) + 4'h1);
    end
  end

  // Power-down next state: leave as soon as the sleep pin is low, and
  // enter only on its rising edge with acknowledge already low. A rise
  // that meets acknowledge high is refused and the block stays awake.
  always_comb begin
    sleep_d = sleep_q;
    if (!sleepSync_q[1]) begin
      sleep_d = 1'b0;
    end else if (sleepRise && !ackSync_q[1]) begin
      sleep_d = 1'b1;
    end
  end

  // Power-down register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  // Early steering follows the detector while awake and is frozen while
  // asleep, so tone changes then cannot disturb the host's view.
  always_comb begin
    steer_d = toneValid;
    if (sleep_q) begin
      steer_d = steer_q;
    end
  end

  // Early-steering register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      steer_q <= 1'b0;
    end else begin
      steer_q <= steer_d;
    end
  end

  // Shifter next state. Acknowledge rises are only taken while awake and
  // while a key is present; after the fourth bit the shifter waits in the
  // done state, so further rises are ignored until the key drops or a
  // sleep cycle rearms it for another read.
  always_comb begin
    state_d  = state_q;
    shift_d  = shift_q;
    count_d  = count_q;
    serial_d = serial_q;
    if (sleep_q) begin
      // Reads restart after each sleep so a held key can be reread.
      if (state_q == TKSR_DONE) begin
        state_d = TKSR_IDLE;
      end
    end else if (!toneValid) begin
      if (state_q == TKSR_DONE) begin
        state_d = TKSR_IDLE;
      end
    end else if (ackRise) begin
      case (state_q)
        TKSR_IDLE: begin
          shift_d  = {1'b0, keyCode[3:1]};
          serial_d = keyCode[0];
          count_d  = 3'h1;
          state_d  = TKSR_SHIFT;
        end
        TKSR_SHIFT: begin
          serial_d = shift_q[0];
          shift_d  = {1'b0, shift_q[3:1]};
          count_d  = 3'(count_q + 3'h1);
          if (count_q == 3'(tksr_pkg::BitsPerKey - 1)) begin
            state_d = TKSR_DONE;
          end
        end
        default: begin
          state_d = TKSR_DONE;
        end
      endcase
    end
  end

  // Shifter registers; the reset only stands in for the unknown
  // power-up state, which the first key sequence would otherwise settle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q  <= TKSR_IDLE;
      shift_q  <= tksr_pkg::CodeReset;
      count_q  <= tksr_pkg::CountReset;
      serial_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      shift_q  <= shift_d;
      count_q  <= count_d;
      serial_q <= serial_d;
    end
  end

  // Outputs come straight from registers.
  assign link.earlySteering = steer_q;
  assign link.serialCode    = serial_q;
  assign sleeping           = sleep_q;

endmodule

// *** hdl/tksr_fifo.sv ***
/*
  Parameterised flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module tksr_fifo #(
  parameter int unsigned Width = 4,
  parameter int unsigned Depth = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [Width-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [Width-1:0]      outData
);
  localparam int unsigned Aw = $clog2(Depth);

  logic [Width-1:0] mem_q [Depth];
  logic [Aw-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [Aw:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign inReady  = (cnt_q != (Aw+1)'(Depth));
  assign outValid = (cnt_q != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem_q[rd_q];

  // Pointer and fill-level next values.
  always_comb begin
    wr_d  = push ? Aw'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? Aw'(rd_q + 1'b1) : rd_q;
    cnt_d = (Aw+1)'(cnt_q + {{Aw{1'b0}}, push} - {{Aw{1'b0}}, pop});
  end

  // Pointer registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage entries, one write enable each.
  for (genvar i = 0; i < Depth; i++) begin : gEntry
    always_ff @(posedge clk) begin
      if (push && wr_q == Aw'(i)) begin
        mem_q[i] <= inData;
      end
    end
  end
endmodule

// *** hdl/tksr_host.sv ***
/*
  Host end: four dummy acknowledges after reset, then reads one code
  per early-steering rise or sleep cycle with the key held, and pushes it into a FIFO for the user.
  Assumes link inputs are asynchronous and pass two flip-flops.
*/
`timescale 1ns/1ps
module tksr_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  tksr_link_if.host        link,
  input  wire logic        sleepCmd,
  output logic             keyValid,
  input  wire logic        keyReady,
  output logic [3:0]       keyCode
);
  typedef enum logic [2:0] {
    TKSR_INIT, TKSR_WAIT, TKSR_GUARD, TKSR_HIGH, TKSR_LOW, TKSR_PUSH,
    TKSR_HOLD
  } tksr_hstate_t;

  tksr_hstate_t state_q, state_d;
  logic [1:0]  steerSync_q, sdSync_q;
  logic [7:0]  timer_q, timer_d;
  logic [2:0]  bits_q, bits_d;
  logic        dummy_q, dummy_d;
  logic [3:0]  code_q, code_d;
  logic        ack_q, ack_d, sleep_q, sleep_d;
  logic        fifoReady, push;

  // Link input synchronisers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      steerSync_q <= 2'h0;
      sdSync_q    <= 2'h0;
    end else begin
      steerSync_q <= {steerSync_q[0], link.earlySteering};
      sdSync_q    <= {sdSync_q[0], link.serialCode};
    end
  end

  assign push = (state_q == TKSR_PUSH);

  // Sequencer: guard, four acknowledge pulses, sample after each rise.
  always_comb begin
    state_d = state_q;
    timer_d = (timer_q != 8'h0) ? 8'(timer_q - 8'h1) : 8'h0;
    bits_d  = bits_q;
    dummy_d = dummy_q;
    code_d  = code_q;
    ack_d   = ack_q;
    sleep_d = sleep_q;
    case (state_q)
      TKSR_INIT: begin
        dummy_d = 1'b1;
        bits_d  = 3'h0;
        state_d = TKSR_HIGH;
      end
      TKSR_WAIT: begin
        // Acknowledge stays low here, so raising sleep is legal.
        sleep_d = sleepCmd && !steerSync_q[1];
        if (steerSync_q[1] && !sleepCmd) begin
          sleep_d = 1'b0;
          timer_d = 8'(tksr_pkg::GuardCycles);
          state_d = TKSR_GUARD;
        end
      end
      TKSR_GUARD: begin
        if (!steerSync_q[1]) begin
          state_d = TKSR_WAIT;
        end else if (timer_q == 8'h0) begin
          bits_d  = 3'h0;
          dummy_d = 1'b0;
          state_d = TKSR_HIGH;
        end
      end
      TKSR_HIGH: begin
        ack_d   = 1'b1;
        timer_d = 8'(tksr_pkg::AckHalfCycles + 4);
        state_d = TKSR_LOW;
      end
      TKSR_LOW: begin
        if (timer_q == 8'h0 && ack_q) begin
          code_d  = {sdSync_q[1], code_q[3:1]};
          ack_d   = 1'b0;
          timer_d = 8'(tksr_pkg::AckHalfCycles + 4);
        end else if (timer_q == 8'h0) begin
          bits_d = 3'(bits_q + 3'h1);
          if (bits_q == 3'(tksr_pkg::BitsPerKey - 1)) begin
            state_d = dummy_q ? TKSR_WAIT : TKSR_PUSH;
          end else begin
            state_d = TKSR_HIGH;
          end
        end
      end
      TKSR_PUSH: begin
        if (fifoReady) begin
          state_d = TKSR_HOLD;
        end
      end
      default: begin
        // Wait for the key to drop; a sleep cycle also allows a reread.
        if (!steerSync_q[1]) begin
          state_d = TKSR_WAIT;
        end else if (sleepCmd) begin
          sleep_d = 1'b1;
        end else if (sleep_q) begin
          sleep_d = 1'b0;
          state_d = TKSR_WAIT;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= TKSR_INIT;
      timer_q <= 8'h0;
      bits_q  <= tksr_pkg::CountReset;
      dummy_q <= 1'b0;
      code_q  <= tksr_pkg::CodeReset;
      ack_q   <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      bits_q  <= bits_d;
      dummy_q <= dummy_d;
      code_q  <= code_d;
      ack_q   <= ack_d;
      sleep_q <= sleep_d;
    end
  end

  assign link.ackPulse     = ack_q;
  assign link.sleepRequest = sleep_q;

  tksr_fifo #(
    .Width (tksr_pkg::FifoWidth),
    .Depth (tksr_pkg::FifoDepth)
  ) uFifo (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (push),
    .inReady  (fifoReady),
    .inData   (code_q),
    .outValid (keyValid),
    .outReady (keyReady),
    .outData  (keyCode)
  );
endmodule

// *** dv/tksr_link_properties.sv ***
/* Concurrent checks on the link between the device and host ends.
   Assumes one clock domain; the bench instantiates it beside the link. */
`timescale 1ns/1ps
module tksr_link_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic earlySteering,
  input wire logic serialCode,
  input wire logic ackPulse,
  input wire logic sleepRequest
);
  logic [2:0] ackCount_q;
  logic [2:0] ackCount_d;
  logic       ackLast_q;
  logic       steerLast_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Counts acknowledge rises per key; a sleep restarts the count.
  always_comb begin
    ackCount_d = ackCount_q;
    if ((earlySteering && !steerLast_q) || sleepRequest) begin
      ackCount_d = 3'h0;
    end else if (ackPulse && !ackLast_q && ackCount_q != 3'h7) begin
      ackCount_d = ackCount_q + 3'h1;
    end
  end

  // Registers the count and the previous pin levels.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackCount_q  <= 3'h0;
      ackLast_q   <= 1'b0;
      steerLast_q <= 1'b0;
    end else begin
      ackCount_q  <= ackCount_d;
      ackLast_q   <= ackPulse;
      steerLast_q <= earlySteering;
    end
  end

  // A pulse stands high ten cycles and rests low at least nine.
  sequence s_high_ten;
    ackPulse [*8] ##1 ackPulse ##1 ackPulse ##1 !ackPulse;
  endsequence
  sequence s_low_nine;
    !ackPulse [*8] ##1 !ackPulse;
  endsequence

  a_ack_high_len: assert property ($rose(ackPulse) |-> s_high_ten)
    else $error("ack high time wrong");
  a_ack_low_len: assert property ($fell(ackPulse) |-> s_low_nine)
    else $error("ack low time wrong");
  a_code_after_ack: assert property ($changed(serialCode) |->
    $past(ackPulse, 3) && !$past(ackPulse, 5))
    else $error("serial bit moved without ack");
  a_extra_ack_ignored: assert property ($changed(serialCode) |->
    $past(ackCount_q, 4) < 3'h4)
    else $error("serial bit moved on fifth ack");
  a_four_per_key: assert property ($changed(earlySteering) |->
    ackCount_q == 3'h4)
    else $error("ack count per key not four");
  a_ack_sleep_excl: assert property (!(ackPulse && sleepRequest))
    else $error("ack and sleep high together");
  a_sleep_ack_low: assert property ($rose(sleepRequest) |->
    !$past(ackPulse))
    else $error("sleep raised with ack high");
  a_sleep_frozen: assert property (sleepRequest &&
    $past(sleepRequest) |-> $stable(earlySteering) && $stable(serialCode))
    else $error("link moved during sleep");
endmodule

// *** dv/tone_key_serial_readout_tb_top.sv ***
/* Self-checking bench: device and host ends joined by the link.
   Assumes the package, interface, both ends and checker are compiled. */
`timescale 1ns/1ps
module tone_key_serial_readout_tb_top;
  logic                clk, nrst, toneValid, sleepCmd, keyReady;
  logic                sleeping, keyValid, ackSeen;
  logic [3:0]          keyCode, wireBits;
  tksr_pkg::tksr_idx_t rowIdx, colIdx;
  int                  fail_count, compares, ackGoal;
  int                  ackFalls = 0;

  tksr_link_if link ();
  tksr_device tksr_device_inst (.clk(clk), .nrst(nrst), .link(link),
    .toneValid(toneValid), .rowIdx(rowIdx), .colIdx(colIdx),
    .sleeping(sleeping));
  tksr_host tksr_host_inst (.clk(clk), .nrst(nrst), .link(link),
    .sleepCmd(sleepCmd), .keyValid(keyValid), .keyReady(keyReady),
    .keyCode(keyCode));
  tksr_link_properties tksr_link_properties_inst (.clk(clk), .nrst(nrst),
    .earlySteering(link.earlySteering), .serialCode(link.serialCode),
    .ackPulse(link.ackPulse), .sleepRequest(link.sleepRequest));

  // Free-running clock of 8 ns period.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Shifts in the wire, first bit lowest, as each acknowledge ends.
  always @(negedge clk) begin
    ackSeen <= link.ackPulse;
    if (ackSeen === 1'b1 && link.ackPulse === 1'b0) begin
      wireBits <= {link.serialCode, wireBits[3:1]};
      ackFalls <= ackFalls + 1;
    end
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares a code.
  task automatic check_code(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t code %h not %h", $time, got, exp);
    end
  endtask

  // Compares a flag.
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag %b not %b", $time, got, exp);
    end
  endtask

  // Waits for a condition at falling edges; a spent bound ends the run.
  task automatic wait_for(input int which, input logic lvl);
    logic s;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      s = (which == 0) ? keyValid : (which == 1) ? sleeping :
          (which == 2) ? link.earlySteering : (ackFalls >= ackGoal);
      if (s === lvl) begin
        return;
      end
    end
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask

  // Expected code of a row and column pair.
  function automatic logic [3:0] key_code(input int r, input int c);
    if (c == 3) begin
      return (r == 3) ? tksr_pkg::KeyD : tksr_pkg::KeyA + 4'(r);
    end
    if (r == 3) begin
      return (c == 0) ? tksr_pkg::KeyStar :
             (c == 1) ? tksr_pkg::KeyZero : tksr_pkg::KeyHash;
    end
    return 4'(r * 3 + c + 1);
  endfunction

  // Presents a key and waits for early steering.
  task automatic press(input int r, input int c);
    rowIdx = 2'(r);
    colIdx = 2'(c);
    toneValid = 1'b1;
    ackGoal = ackFalls + 4;
    wait_for(2, 1'b1);
  endtask

  // Waits for four wire bits and checks them and the pins beside them.
  task automatic read_wire(input logic [3:0] exp);
    wait_for(3, 1'b1);
    check_code(wireBits, exp);
    check_bit(link.earlySteering, 1'b1);
    check_bit(sleeping, 1'b0);
  endtask

  // Pops the head of the host buffer and checks it.
  task automatic pop_check(input logic [3:0] exp);
    wait_for(0, 1'b1);
    check_code(keyCode, exp);
    keyReady = 1'b1;
    @(negedge clk);
    keyReady = 1'b0;
  endtask

  // Removes the tone and lets the link settle.
  task automatic release_key();
    toneValid = 1'b0;
    wait_for(2, 1'b0);
    repeat (20) @(negedge clk);
  endtask

  // Every pair once, read on the wire and from the host.
  task automatic all_keys();
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        press(r, c);
        read_wire(key_code(r, c));
        pop_check(key_code(r, c));
        release_key();
      end
    end
  endtask

  // Two sleeps while a key is held give three reads and no more.
  task automatic reread();
    press(3, 2);
    read_wire(tksr_pkg::KeyHash);
    pop_check(tksr_pkg::KeyHash);
    for (int n = 0; n < 2; n++) begin
      sleepCmd = 1'b1;
      wait_for(1, 1'b1);
      repeat (20) @(negedge clk);
      check_bit(link.earlySteering, 1'b1);
      ackGoal = ackFalls + 4;
      sleepCmd = 1'b0;
      read_wire(tksr_pkg::KeyHash);
      pop_check(tksr_pkg::KeyHash);
    end
    check_bit(keyValid, 1'b0);
    release_key();
  endtask

  // The user stalls while the buffer fills, then drains it in order.
  task automatic fill_drain();
    for (int k = 0; k < int'(tksr_pkg::FifoDepth); k++) begin
      press(k % 4, k / 8);
      read_wire(key_code(k % 4, k / 8));
      release_key();
    end
    for (int k = 0; k < int'(tksr_pkg::FifoDepth); k++) begin
      pop_check(key_code(k % 4, k / 8));
    end
    check_bit(keyValid, 1'b0);
  endtask

  // Reset, wait for the host's dummy pulses, then run the scenarios.
  initial begin
    nrst = 1'b0;
    toneValid = 1'b0;
    sleepCmd = 1'b0;
    keyReady = 1'b0;
    rowIdx = 2'h0;
    colIdx = 2'h0;
    fail_count = 0;
    compares = 0;
    ackGoal = 4;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    wait_for(3, 1'b1);
    all_keys();
    reread();
    fill_drain();
    give_verdict();
  end
endmodule
